// *** src/data_logger.v ***
// Purpose: multichannel data logger with continuous and triggered capture
// Assumes: quantities, cycle pulse and event pulses come from CLK logic
// Notes:   registers over APB, one wait state on every access
// Operation
// RULE_01 - each sampling instant records all eight configured channels
// RULE_02 - interval is one cycle, one second or 1..60 minutes
// RULE_03 - changing any logger setting erases the whole log
// RULE_04 - continuous mode keeps 4096 samples circularly, oldest overwritten
// RULE_05 - trigger mode stores each record in its own buffer, up to fifteen
// RULE_06 - gather pre-trigger, fill on trigger, then move to next buffer
// RULE_07 - with all buffers full a new trigger overwrites the oldest
// RULE_08 - partition is 2x2048, 4x1024, 8x512 or 16x256 samples
// RULE_09 - one buffer stays reserved, so N buffers hold N-1 records
// RULE_10 - pre-trigger share is 0 to 100 percent in 1 percent steps
// RULE_11 - zero share starts at trigger; full share keeps only pre-trigger
// RULE_12 - early trigger fills the rest of the buffer with post samples
// RULE_13 - each buffer reports where its trigger point lies
// RULE_14 - per event type enables pick triggers, only in trigger mode
// RULE_15 - partition and share have no effect in continuous mode
// RULE_16 - each channel selects any analog quantity or disabled
// RULE_17 - all channels disabled means no sampling and no triggers
// RULE_18 - triggers during post-trigger filling are ignored
`timescale 1ns/1ps
`default_nettype none
`include "logger_map.vh"

module data_logger #(
	parameter CYCLES_PER_SEC = `CLK_HZ
) (
	input  wire         CLK,        // 250 MHz system clock
	input  wire         RESET,      // synchronous, active high
	input  wire         PSEL,       // apb select
	input  wire         PENABLE,    // apb access phase
	input  wire         PWRITE,     // apb direction
	input  wire [11:0]  PADDR,      // apb byte address
	input  wire [31:0]  PWDATA,     // apb write data
	output reg  [31:0]  PRDATA,     // apb read data
	output reg          PREADY,     // apb ready
	output reg          PSLVERR,    // apb error, unmapped address
	input  wire [239:0] QUANTITY,   // fifteen 16-bit analog quantities
	input  wire         CYCLE_TICK, // one pulse per power cycle
	input  wire         EV_PICKUP,  // pickup event pulse
	input  wire         EV_DROPOUT, // dropout event pulse
	input  wire         EV_TRIP,    // trip event pulse
	input  wire         EV_ALARM,   // alarm event pulse
	input  wire         EV_CONTROL  // control event pulse
);
	reg  [31:0]  ctrl_r;
	reg  [31:0]  src_r;
	reg  [14:0]  rd_addr_r;
	reg  [3:0]   buf_sel_r;
	reg          clear_r;
	// continuous store
	reg  [11:0]  cont_ptr_r;
	reg  [12:0]  cont_cnt_r;
	// triggered store
	reg  [3:0]   cur_buf_r;
	reg  [10:0]  off_r;
	reg  [11:0]  coll_r;
	reg  [11:0]  post_left_r;
	reg          post_r;
	reg          pend_r;
	reg  [15:0]  valid_r;
	reg  [4:0]   held_r;
	reg  [10:0]  trig_off_r [0:15];
	reg  [10:0]  start_off_r [0:15];

	wire         tick;
	wire [15:0]  rd_word;
	wire         cont;
	wire [1:0]   part;
	wire [6:0]   pct;
	wire [4:0]   ev_en;
	wire         any_en;
	wire [11:0]  bsize;
	wire [4:0]   nbuf;
	wire [11:0]  pre_tgt;
	wire [11:0]  kept;
	wire [11:0]  rem;
	wire [11:0]  base;
	wire         trig_ev;
	wire         trig_now;
	wire         wr_en;
	wire [11:0]  wr_addr;
	wire         apb_wr;
	wire         apb_rd;
	reg  [127:0] row;
	reg  [31:0]  rd_mux;
	reg          mapped;
	integer      i;

	function [15:0] pick;
		input [3:0]   sel;
		input [239:0] q;
		begin
			if (sel == 4'h0)
				pick = 16'h0000;
			else
				pick = q[(sel - 4'h1)*16 +: 16];
		end
	endfunction

	function [11:0] buf_size;
		input [1:0] p;
		begin
			buf_size = 12'h800 >> p;
		end
	endfunction

	function [11:0] pre_target;
		input [11:0] size;
		input [6:0]  share;
		reg   [18:0] prod;
		reg   [18:0] quot;
		begin
			prod = {7'h00, size} * {12'h000, (share > `PCT_FULL) ?
				`PCT_FULL : share};
			quot = prod / 19'h00064;
			pre_target = quot[11:0];
		end
	endfunction

	assign cont   = ctrl_r[`CTRL_CONT];
	assign part   = ctrl_r[`CTRL_PART_HI:`CTRL_PART_LO];
	assign pct    = ctrl_r[`CTRL_PCT_HI:`CTRL_PCT_LO];
	assign ev_en  = ctrl_r[`CTRL_EN_HI:`CTRL_EN_LO];
	assign any_en = |src_r; // RULE_17

	// partition and share are read only by the triggered path
	assign bsize   = buf_size(part); // RULE_08 RULE_15
	assign nbuf    = 5'h02 << part; // RULE_08
	assign pre_tgt = pre_target(bsize, pct); // RULE_10
	assign kept    = (coll_r < pre_tgt) ? coll_r : pre_tgt; // RULE_12
	assign rem     = bsize - kept; // RULE_11
	assign base    = {8'h00, cur_buf_r} << (4'hB - {2'b00, part});

	assign trig_ev = |({EV_CONTROL, EV_ALARM, EV_TRIP, EV_DROPOUT,
		EV_PICKUP} & ev_en); // RULE_14
	// a pending trigger is acted on away from a sample instant, so a
	// sample never lands on both sides of the trigger point
	assign trig_now = pend_r && !tick && !post_r;
	assign wr_en    = tick && any_en && !clear_r; // RULE_17
	assign wr_addr  = cont ? cont_ptr_r : (base | {1'b0, off_r});

	assign apb_wr = PSEL && PENABLE && !PREADY && PWRITE;
	assign apb_rd = PSEL && PENABLE && !PREADY && !PWRITE;

	always @* begin
		row = 128'h0;
		for (i = 0; i < `CHANNELS; i = i + 1)
			row[i*16 +: 16] = pick(src_r[i*4 +: 4], QUANTITY); // RULE_16
	end

	sample_tick_gen #(
		.CYCLES_PER_SEC(CYCLES_PER_SEC)
	) u_tick (
		.clk       (CLK),
		.reset     (RESET),
		.restart   (clear_r),
		.rate      (ctrl_r[`CTRL_RATE_HI:`CTRL_RATE_LO]),
		.cycle_tick(CYCLE_TICK),
		.tick_r    (tick)
	);

	log_store u_store (
		.clk    (CLK),
		.wr_en  (wr_en), // RULE_01
		.wr_addr(wr_addr),
		.wr_data(row),
		.rd_addr(rd_addr_r[11:0]),
		.rd_chan(rd_addr_r[14:12]),
		.rd_data(rd_word)
	);

	// settings and the clear they cause
	always @(posedge CLK) begin
		if (RESET) begin
			ctrl_r    <= `CTRL_RESET;
			src_r     <= `SRC_RESET;
			rd_addr_r <= 15'h0000;
			buf_sel_r <= 4'h0;
			clear_r   <= 1'b1;
		end else begin
			clear_r <= 1'b0;
			if (apb_wr) begin
				case (PADDR)
					`OFS_CTRL: begin
						ctrl_r <= PWDATA & `CTRL_MASK;
						if ((PWDATA & `CTRL_MASK) != ctrl_r)
							clear_r <= 1'b1; // RULE_03
					end
					`OFS_SRC: begin
						src_r <= PWDATA;
						if (PWDATA != src_r)
							clear_r <= 1'b1; // RULE_03
					end
					`OFS_RD_ADDR: rd_addr_r <= PWDATA[14:0];
					`OFS_BUF_SEL: buf_sel_r <= PWDATA[3:0];
					default: ;
				endcase
			end
		end
	end

	// continuous circular log
	always @(posedge CLK) begin
		if (RESET || clear_r) begin
			cont_ptr_r <= 12'h000;
			cont_cnt_r <= 13'h0000;
		end else if (wr_en && cont) begin
			cont_ptr_r <= cont_ptr_r + 12'h001; // RULE_04
			if (cont_cnt_r != `DEPTH)
				cont_cnt_r <= cont_cnt_r + 13'h0001;
		end
	end

	// triggered capture buffers
	always @(posedge CLK) begin
		if (RESET || clear_r) begin
			cur_buf_r   <= 4'h0;
			off_r       <= 11'h000;
			coll_r      <= 12'h000;
			post_left_r <= 12'h000;
			post_r      <= 1'b0;
			pend_r      <= 1'b0;
			valid_r     <= 16'h0000;
			held_r      <= 5'h00;
		end else if (!cont && any_en) begin // RULE_14 RULE_17
			if (trig_ev && !post_r)
				pend_r <= 1'b1;
			else if (trig_now)
				pend_r <= 1'b0;
			if (trig_ev && post_r)
				pend_r <= 1'b0; // RULE_18
			if (trig_now) begin
				trig_off_r[cur_buf_r]  <= off_r; // RULE_13
				start_off_r[cur_buf_r] <= (off_r - kept[10:0]) &
					(bsize[10:0] - 11'h001);
				if (rem == 12'h000) begin // RULE_11
					valid_r[cur_buf_r] <= 1'b1;
					cur_buf_r <= (cur_buf_r + 4'h1) & (nbuf[3:0] - 4'h1);
					valid_r[(cur_buf_r + 4'h1) & (nbuf[3:0] - 4'h1)] <= 1'b0;
					off_r  <= 11'h000;
					coll_r <= 12'h000;
					if (held_r != nbuf - 5'h01)
						held_r <= held_r + 5'h01; // RULE_09
				end else begin
					post_r      <= 1'b1; // RULE_06
					post_left_r <= rem; // RULE_12
				end
			end else if (tick) begin
				off_r <= (off_r + 11'h001) & (bsize[10:0] - 11'h001);
				if (!post_r && coll_r != bsize)
					coll_r <= coll_r + 12'h001; // RULE_06
				if (post_r) begin
					post_left_r <= post_left_r - 12'h001;
					if (post_left_r == 12'h001) begin
						valid_r[cur_buf_r] <= 1'b1; // RULE_05
						// the next buffer is the reserved one; its old
						// record is the oldest and is given up here
						cur_buf_r <= (cur_buf_r + 4'h1) &
							(nbuf[3:0] - 4'h1); // RULE_07
						valid_r[(cur_buf_r + 4'h1) &
							(nbuf[3:0] - 4'h1)] <= 1'b0; // RULE_09
						off_r  <= 11'h000;
						coll_r <= 12'h000;
						post_r <= 1'b0; // RULE_06
						if (held_r != nbuf - 5'h01)
							held_r <= held_r + 5'h01; // RULE_09
					end
				end
			end
		end
	end

	always @* begin
		mapped = 1'b1;
		rd_mux = 32'h00000000;
		case (PADDR)
			`OFS_CTRL:     rd_mux = ctrl_r;
			`OFS_SRC:      rd_mux = src_r;
			`OFS_STATUS:   rd_mux = {3'h0, any_en, 2'h0, held_r,
				cur_buf_r, post_r, 3'h0, cont_cnt_r};
			`OFS_RD_ADDR:  rd_mux = {17'h00000, rd_addr_r};
			`OFS_RD_DATA:  rd_mux = {16'h0000, rd_word};
			`OFS_BUF_SEL:  rd_mux = {28'h0000000, buf_sel_r};
			`OFS_BUF_INFO: rd_mux = {valid_r[buf_sel_r], 8'h00,
				trig_off_r[buf_sel_r], 1'b0, start_off_r[buf_sel_r]}; // RULE_13
			`OFS_CONT_PTR: rd_mux = {20'h00000, cont_ptr_r};
			default:       mapped = 1'b0;
		endcase
	end

	// one wait state: ready rises in the second access cycle
	always @(posedge CLK) begin
		if (RESET) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end else begin
			PREADY  <= PSEL && PENABLE && !PREADY;
			PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
			if (apb_rd)
				PRDATA <= rd_mux;
		end
	end
endmodule // data_logger
`default_nettype wire

// *** src/log_store.v ***
// Purpose: sample memory, one row holds all eight channels of an instant
// Assumes: single writer, registered read
// Notes:   contents survive a clear; the logger hides them by its counts
`timescale 1ns/1ps
`default_nettype none
`include "logger_map.vh"

module log_store (
	input  wire         clk,     // system clock
	input  wire         wr_en,   // write one row
	input  wire [11:0]  wr_addr, // row written
	input  wire [127:0] wr_data, // eight channel values
	input  wire [11:0]  rd_addr, // row read
	input  wire [2:0]   rd_chan, // channel read
	output reg  [15:0]  rd_data  // registered channel value
);
	reg [127:0] mem [0:`DEPTH-1];

	always @(posedge clk) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr][rd_chan*16 +: 16];
	end
endmodule // log_store
`default_nettype wire

// *** src/logger_map.vh ***
// Purpose: register offsets, field positions, reset values and timing
//          constants of the multichannel data logger
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   definitions only
`ifndef LOGGER_MAP_VH
`define LOGGER_MAP_VH

// register byte offsets
`define OFS_CTRL        12'h000
`define OFS_SRC         12'h004
`define OFS_STATUS      12'h008
`define OFS_RD_ADDR     12'h00C
`define OFS_RD_DATA     12'h010
`define OFS_BUF_SEL     12'h014
`define OFS_BUF_INFO    12'h018
`define OFS_CONT_PTR    12'h01C

// control register fields
`define CTRL_CONT       0
`define CTRL_PART_LO    1
`define CTRL_PART_HI    2
`define CTRL_PCT_LO     4
`define CTRL_PCT_HI     10
`define CTRL_EN_LO      11
`define CTRL_EN_HI      15
`define CTRL_RATE_LO    16
`define CTRL_RATE_HI    19
`define CTRL_MASK       32'h000FFFF7
// continuous off, 16 x 256, 25 percent, every event type enabled, 1 cycle
`define CTRL_RESET      32'h0000F996
// channel quantity selectors, 4 bits each, code 0 means disabled
`define SRC_RESET       32'h87654321

// sample interval codes
`define RATE_CYCLE      4'h0
`define RATE_SECOND     4'h1
`define RATE_MIN1       4'h2
`define RATE_MIN5       4'h3
`define RATE_MIN10      4'h4
`define RATE_MIN15      4'h5
`define RATE_MIN20      4'h6
`define RATE_MIN30      4'h7
`define RATE_MIN60      4'h8

// storage geometry
`define CHANNELS        8
`define SAMPLE_W        16
`define DEPTH           4096
`define MAX_BUF_LOG2    11
`define PCT_FULL        7'h64

// timing
`define CLK_HZ          250000000
`define SEC_PER_MIN     6'h3C

`endif

// *** src/sample_tick_gen.v ***
// Purpose: sampling instant generator for the data logger
// Assumes: power-cycle pulse comes from logic on CLK
// Notes:   restart realigns the second and minute intervals to the moment of a log clear; the cycle interval follows cycle_tick
`timescale 1ns/1ps
`default_nettype none
`include "logger_map.vh"

module sample_tick_gen #(
	parameter CYCLES_PER_SEC = `CLK_HZ
) (
	input  wire       clk,        // system clock
	input  wire       reset,      // synchronous reset
	input  wire       restart,    // realign after a clear
	input  wire [3:0] rate,       // interval code
	input  wire       cycle_tick, // one pulse per power cycle
	output reg        tick_r      // sampling instant pulse
);
	reg  [27:0] sec_cnt_r;
	reg  [5:0]  sec_in_min_r;
	reg  [5:0]  min_cnt_r;
	wire        sec_pulse;
	wire        min_pulse;

	function [5:0] minutes;
		input [3:0] code;
		begin
			case (code)
				`RATE_MIN1:  minutes = 6'h01;
				`RATE_MIN5:  minutes = 6'h05;
				`RATE_MIN10: minutes = 6'h0A;
				`RATE_MIN15: minutes = 6'h0F;
				`RATE_MIN20: minutes = 6'h14;
				`RATE_MIN30: minutes = 6'h1E;
				default:     minutes = 6'h3C;
			endcase
		end
	endfunction

	assign sec_pulse = (sec_cnt_r == CYCLES_PER_SEC[27:0] - 28'h0000001);
	assign min_pulse = sec_pulse && (sec_in_min_r == `SEC_PER_MIN - 6'h01);

	always @(posedge clk) begin
		if (reset || restart) begin
			sec_cnt_r    <= 28'h0000000;
			sec_in_min_r <= 6'h00;
			min_cnt_r    <= 6'h00;
			tick_r       <= 1'b0;
		end else begin
			sec_cnt_r <= sec_pulse ? 28'h0000000 : sec_cnt_r + 28'h0000001;
			if (sec_pulse)
				sec_in_min_r <= min_pulse ? 6'h00 : sec_in_min_r + 6'h01;
			if (min_pulse)
				min_cnt_r <= (min_cnt_r == minutes(rate) - 6'h01) ?
					6'h00 : min_cnt_r + 6'h01;
			case (rate) // RULE_02
				`RATE_CYCLE:  tick_r <= cycle_tick;
				`RATE_SECOND: tick_r <= sec_pulse;
				default:      tick_r <= min_pulse &&
					(min_cnt_r == minutes(rate) - 6'h01);
			endcase
		end
	end
endmodule // sample_tick_gen
`default_nettype wire

// *** tb/data_logger_assertions.sv ***
// Purpose: bus-side checks for the data logger
// Assumes: one wait state on every access
// Notes:   bound to data_logger, watches its bus ports only
`timescale 1ns/1ps
`default_nettype none
`include "logger_map.vh"
module data_logger_assertions (
	input wire logic        CLK,     // clock
	input wire logic        RESET,   // sync reset
	input wire logic        PSEL,    // select
	input wire logic        PENABLE, // access phase
	input wire logic        PWRITE,  // direction
	input wire logic [11:0] PADDR,   // address
	input wire logic [31:0] PWDATA,  // write data
	input wire logic [31:0] PRDATA,  // read data
	input wire logic        PREADY,  // ready
	input wire logic        PSLVERR  // error
);
	logic [31:0] ctrl_r;
	logic [31:0] src_r;
	wire         wr_done = PREADY && PWRITE && !PSLVERR;
	// shadows follow the bus, so readback is judged without design internals
	always_ff @(posedge CLK) begin
		if (RESET) begin
			ctrl_r <= `CTRL_RESET;
			src_r  <= `SRC_RESET;
		end else if (wr_done && PADDR == `OFS_CTRL) begin
			ctrl_r <= PWDATA & `CTRL_MASK;
		end else if (wr_done && PADDR == `OFS_SRC) begin
			src_r <= PWDATA;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	sequence s_access;
		PSEL && PENABLE && !PREADY;
	endsequence
	sequence s_answer;
		PREADY ##1 !PREADY;
	endsequence
	a_one_wait: assert property (s_access |=> s_answer)
		else $error("answer not one cycle after access");
	a_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE))
		else $error("ready without access");
	a_idle_quiet: assert property (!PSEL |=> !PREADY)
		else $error("ready while idle");
	a_err_unmapped: assert property (PSEL && PENABLE && !PREADY && PADDR >= 12'h020 |=> PSLVERR)
		else $error("no error on unmapped address");
	a_err_mapped: assert property (PSEL && PENABLE && !PREADY && PADDR < 12'h020 && PADDR[1:0] == 2'b00 |=> !PSLVERR)
		else $error("error on mapped address");
	a_err_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
		else $error("unmapped read not zero");
	a_data_holds: assert property (!(PREADY && !PWRITE) |-> $stable(PRDATA))
		else $error("read data moved between reads");
	a_ctrl_back: assert property (PREADY && !PWRITE && PADDR == `OFS_CTRL |-> PRDATA == ctrl_r)
		else $error("control readback wrong");
	a_src_back: assert property (PREADY && !PWRITE && PADDR == `OFS_SRC |-> PRDATA == src_r)
		else $error("source readback wrong");
	a_count_sat: assert property (PREADY && !PWRITE && PADDR == `OFS_STATUS |-> PRDATA[12:0] <= 13'h1000)
		else $error("sample count above depth");
endmodule // data_logger_assertions
bind data_logger data_logger_assertions chk_u (.CLK(CLK), .RESET(RESET),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
`default_nettype wire

// *** tb/data_logger_tb_top.sv ***
// Purpose: self-checking bench for the data logger
// Assumes: one second shortened to ten clocks
// Notes:   expected rows follow the feed model's sample index
`timescale 1ns/1ps
`default_nettype none
`include "logger_map.vh"
module data_logger_tb_top;
	localparam int CPS = 10;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] seed = 32'h5090;
	logic [31:0] rd;
	logic        err;
	logic [15:0] base;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         cyc;
	wire [239:0] qty;
	wire  [4:0]  ev;
	int          fail_count = 0;
	int          checked = 0;
	int          n;
	int          pre;
	always #2 clk = ~clk;
	data_logger #(.CYCLES_PER_SEC(CPS)) dut_u (.CLK(clk), .RESET(reset),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.QUANTITY(qty), .CYCLE_TICK(cyc), .EV_PICKUP(ev[0]), .EV_DROPOUT(ev[1]),
		.EV_TRIP(ev[2]), .EV_ALARM(ev[3]), .EV_CONTROL(ev[4]));
	relay_feed feed_u (.CLK(clk), .QUANTITY(qty), .CYCLE_TICK(cyc), .EV(ev));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] f_ctrl(input logic c, input logic [1:0] p,
		input logic [6:0] pct, input logic [4:0] en, input logic [3:0] r);
		return {12'h000, r, en, pct, 1'b0, p, c};
	endfunction
	function automatic logic [31:0] f_smp(input int idx, input int c);
		return {16'h0000, 16'(base + idx + (c + 1) * 4096)};
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
			fail_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		conclude();
	end
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		apb(0, `OFS_CTRL, 32'h0);
		chk("ctrl reset", `CTRL_RESET, rd);
		apb(0, `OFS_SRC, 32'h0);
		chk("src reset", `SRC_RESET, rd);
		apb(0, 12'h040, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		apb(1, `OFS_SRC, 32'h0);
		apb(1, `OFS_CTRL, f_ctrl(1, 3, 25, 5'h1F, `RATE_CYCLE));
		repeat (5) feed_u.tick();
		apb(0, `OFS_STATUS, 32'h0);
		chk("idle status", 32'h0, rd & 32'h1000_1FFF);
		apb(1, `OFS_SRC, `SRC_RESET);
		base = feed_u.cnt_r;
		n = 4097 + int'(rnd() % 8);
		repeat (n) feed_u.tick();
		apb(0, `OFS_STATUS, 32'h0);
		chk("count", 32'h1000_1000, rd & 32'h1000_1FFF);
		apb(0, `OFS_CONT_PTR, 32'h0);
		chk("write row", 32'(n - 4096), rd & 32'hFFF);
		for (int c = 0; c < 8; c++) begin
			apb(1, `OFS_RD_ADDR, {17'h0, 3'(c), 12'(c % 2 ? n - 4096 : 0)});
			apb(0, `OFS_RD_DATA, 32'h0);
			chk("sample", f_smp(c % 2 ? n - 4096 : 4096, c), rd & 32'hFFFF);
		end
		feed_u.event_pulse(2);
		apb(0, `OFS_STATUS, 32'h0);
		chk("no fill", 32'h0, rd & 32'h0001_0000);
		apb(1, `OFS_CTRL, f_ctrl(1, 3, 25, 5'h1F, `RATE_SECOND));
		apb(0, `OFS_STATUS, 32'h0);
		chk("cleared", 32'h0, rd & 32'h1FFF);
		repeat (10 * CPS) @(posedge clk);
		apb(0, `OFS_STATUS, 32'h0);
		chk("per second", 32'h1, {31'h0, (rd & 32'h1FFF) inside {[9:11]}});
		for (int t = 0; t < 5; t++) begin
			apb(1, `OFS_CTRL, f_ctrl(0, 3, 25, 5'h01 << t, `RATE_CYCLE));
			feed_u.event_pulse((t + 1) % 5);
			apb(0, `OFS_STATUS, 32'h0);
			chk("other event", 32'h0, rd & 32'h0001_0000);
			feed_u.event_pulse(t);
			apb(0, `OFS_STATUS, 32'h0);
			chk("own event", 32'h0001_0000, rd & 32'h0001_0000);
		end
		apb(1, `OFS_CTRL, f_ctrl(0, 3, 25, 5'h1F, `RATE_CYCLE));
		pre = 1 + int'(rnd() % 50);
		repeat (pre) feed_u.tick();
		feed_u.event_pulse(4);
		feed_u.event_pulse(0);
		repeat (255 - pre) feed_u.tick();
		apb(0, `OFS_STATUS, 32'h0);
		chk("filling", 32'h0001_0000, rd & 32'h03FF_0000);
		feed_u.tick();
		apb(0, `OFS_STATUS, 32'h0);
		chk("done", 32'h0022_0000, rd & 32'h03FF_0000);
		apb(1, `OFS_BUF_SEL, 32'h0);
		apb(0, `OFS_BUF_INFO, 32'h0);
		chk("trigger point", 32'h8000_0000 | 32'(pre << 12), rd & 32'h807F_F7FF);
		apb(1, `OFS_BUF_SEL, 32'h1);
		apb(0, `OFS_BUF_INFO, 32'h0);
		chk("reserved", 32'h0, rd & 32'h8000_0000);
		conclude();
	end
endmodule // data_logger_tb_top
`default_nettype wire

// *** tb/relay_feed.sv ***
// Purpose: relay control logic model: quantities, cycle pulses, events
// Assumes: all outputs change just after a rising edge
// Notes:   quantity k reads sample index plus k in the top nibble
`timescale 1ns/1ps
`default_nettype none
module relay_feed (
	input  wire logic         CLK,        // clock
	output wire logic [239:0] QUANTITY,   // fifteen quantities
	output logic              CYCLE_TICK, // power cycle pulse
	output logic [4:0]        EV          // event pulses
);
	logic [15:0] cnt_r = 16'h0000;
	initial begin
		CYCLE_TICK = 1'b0;
		EV = 5'h00;
	end
	for (genvar k = 1; k < 16; k++) begin : g_q
		assign QUANTITY[k*16-1 -: 16] = cnt_r + 16'(k * 4096);
	end
	// quantities move well after the pulse so the sampled row is unambiguous
	task automatic tick();
		@(posedge CLK) CYCLE_TICK <= 1'b1;
		@(posedge CLK) CYCLE_TICK <= 1'b0;
		repeat (3) @(posedge CLK);
		cnt_r <= cnt_r + 16'h0001;
		@(posedge CLK);
	endtask
	task automatic event_pulse(input int t);
		@(posedge CLK) EV[t] <= 1'b1;
		@(posedge CLK) EV <= 5'h00;
		repeat (3) @(posedge CLK);
	endtask
endmodule // relay_feed
`default_nettype wire
